// ==== verilog/cegr_consts.vh ====
// Offsets, field positions, reset values and widths of the configuration extension registers
`ifndef CEGR_CONSTS_VH
`define CEGR_CONSTS_VH

`define CEGR_ADDR_W           8
`define CEGR_DATA_W           32

`define CEGR_OFF_INT_EVT_SET  8'h80
`define CEGR_OFF_INT_EVT_CLR  8'h84
`define CEGR_OFF_INT_MSK_SET  8'h88
`define CEGR_OFF_INT_MSK_CLR  8'h8C
`define CEGR_OFF_LINK_FEAT    8'hF4
`define CEGR_OFF_SUBSYS_ALIAS 8'hF8
`define CEGR_OFF_GPIO_CTRL    8'hFC

`define CEGR_LINK_ACCEL_BIT   1
`define CEGR_GPIO_IRQ_EN_BIT  31
`define CEGR_GPIO_INV_BIT     29
`define CEGR_GPIO_OE_BIT      28
`define CEGR_GPIO_DATA_BIT    24
`define CEGR_EVT_GPIO_BIT     0

`define CEGR_RST_LINK_ACCEL   1'h0
`define CEGR_RST_SUBSYS       32'h00000000
`define CEGR_RST_GPIO_BIT     1'h0
`define CEGR_RST_EVT          1'h0
`define CEGR_RST_MSK          1'h0

`endif

// ==== verilog/cegr_regs.v ====
// Configuration extension registers: link features, subsystem alias, general pin three control
//
// Local design decision: the strobed register port.
`timescale 1ns/10ps
`include "cegr_consts.vh"

// What this block does
// - Acceleration bit tells PHY link supports acceleration
// - Link bit 6 reserved, reads zero
// - Link bits 5..2 and 0 read zero
// - Alias write also updates subsystem identification
// - Alias read returns last written value
// - Alias bits 31..16 hold subsystem device id
// - Alias bits 15..0 hold subsystem vendor id
// - Alias resets to all zeros
// - Irq enable makes pin level change an event
// - Event and mask registers with set/clear pairs
// - Invert bit flips pin logical polarity
// - Output enable drives pin, else high impedance
// - Control bits 30, 27..25 read zero
// - Data bit read returns pin input value
// - Data bit write stores value to drive
module cegr_regs (
	// Clock and reset
	input  wire        clk,
	input  wire        resetn,
	// Register port
	input  wire [7:0]  reg_addr,
	input  wire [31:0] reg_wdata,
	input  wire        reg_wr,
	input  wire        reg_rd,
	output reg  [31:0] reg_rdata,
	// Link and configuration side
	output reg         link_accel_support,
	output reg  [31:0] subsystem_ident,
	// General pin three
	input  wire        general_pin_three_in,
	output wire        general_pin_three_out,
	output wire        general_pin_three_oe_n,
	// Interrupt
	output wire        irq
);

	reg        rst_meta;
	reg        rst_sync;
	reg [31:0] subsystem_alias;
	reg        pin_three_irq_enable;
	reg        pin_three_invert;
	reg        pin_three_output_enable;
	reg        pin_three_data;
	reg        pin_meta;
	reg        pin_sync;
	reg        pin_prev;
	reg        gpio_event;
	reg        gpio_mask;
	reg        drive_value;
	reg        drive_enable;
	reg [31:0] next_rdata;

	wire       pin_logic_value;
	wire       pin_changed;
	wire       wr_link;
	wire       wr_alias;
	wire       wr_gpio;
	wire       evt_set;
	wire       evt_clr;
	wire       msk_set;
	wire       msk_clr;

	// Reset released through two flops; asserted asynchronously
	always @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			rst_meta <= 1'b0;
			rst_sync <= 1'b0;
		end else begin
			rst_meta <= 1'b1;
			rst_sync <= rst_meta;
		end
	end

	assign wr_link  = reg_wr && (reg_addr == `CEGR_OFF_LINK_FEAT);
	assign wr_alias = reg_wr && (reg_addr == `CEGR_OFF_SUBSYS_ALIAS);
	assign wr_gpio  = reg_wr && (reg_addr == `CEGR_OFF_GPIO_CTRL);

	// Only bit 1 is stored; all other link bits are read-only zero
	always @(posedge clk or negedge rst_sync) begin
		if (!rst_sync) begin
			link_accel_support <= `CEGR_RST_LINK_ACCEL;
		end else if (wr_link) begin
			link_accel_support <= reg_wdata[`CEGR_LINK_ACCEL_BIT];
		end
	end

	// The alias and the identification copy load on the same write
	always @(posedge clk or negedge rst_sync) begin
		if (!rst_sync) begin
			subsystem_alias <= `CEGR_RST_SUBSYS;
			subsystem_ident <= `CEGR_RST_SUBSYS;
		end else if (wr_alias) begin
			subsystem_alias <= reg_wdata;
			subsystem_ident <= reg_wdata;
		end
	end

	always @(posedge clk or negedge rst_sync) begin
		if (!rst_sync) begin
			pin_three_irq_enable    <= `CEGR_RST_GPIO_BIT;
			pin_three_invert        <= `CEGR_RST_GPIO_BIT;
			pin_three_output_enable <= `CEGR_RST_GPIO_BIT;
			pin_three_data          <= `CEGR_RST_GPIO_BIT;
		end else if (wr_gpio) begin
			pin_three_irq_enable    <= reg_wdata[`CEGR_GPIO_IRQ_EN_BIT];
			pin_three_invert        <= reg_wdata[`CEGR_GPIO_INV_BIT];
			pin_three_output_enable <= reg_wdata[`CEGR_GPIO_OE_BIT];
			pin_three_data          <= reg_wdata[`CEGR_GPIO_DATA_BIT];
		end
	end

	// Pin is asynchronous to clk; nothing reads pin_meta but pin_sync
	always @(posedge clk or negedge rst_sync) begin
		if (!rst_sync) begin
			pin_meta <= 1'b0;
			pin_sync <= 1'b0;
			pin_prev <= 1'b0;
		end else begin
			pin_meta <= general_pin_three_in;
			pin_sync <= pin_meta;
			pin_prev <= pin_sync;
		end
	end

	// Change is taken on the raw level so toggling the invert bit raises no event
	assign pin_logic_value = pin_sync ^ pin_three_invert;
	assign pin_changed     = pin_three_irq_enable && (pin_sync != pin_prev);

	// Driven value follows the same polarity as the read-back
	always @(posedge clk or negedge rst_sync) begin
		if (!rst_sync) begin
			drive_value  <= 1'b0;
			drive_enable <= 1'b0;
		end else begin
			drive_value  <= pin_three_data ^ pin_three_invert;
			drive_enable <= pin_three_output_enable;
		end
	end

	assign general_pin_three_out  = drive_value;
	assign general_pin_three_oe_n = ~drive_enable;

	// Clear comes from a write of one or a read of the clear address
	assign evt_set = pin_changed ||
			(reg_wr && (reg_addr == `CEGR_OFF_INT_EVT_SET) && reg_wdata[`CEGR_EVT_GPIO_BIT]);
	assign evt_clr = (reg_addr == `CEGR_OFF_INT_EVT_CLR) &&
			((reg_wr && reg_wdata[`CEGR_EVT_GPIO_BIT]) || reg_rd);
	assign msk_set = reg_wr && (reg_addr == `CEGR_OFF_INT_MSK_SET) && reg_wdata[`CEGR_EVT_GPIO_BIT];
	assign msk_clr = reg_wr && (reg_addr == `CEGR_OFF_INT_MSK_CLR) && reg_wdata[`CEGR_EVT_GPIO_BIT];

	// A new event in the clearing cycle survives: set wins
	always @(posedge clk or negedge rst_sync) begin
		if (!rst_sync) begin
			gpio_event <= `CEGR_RST_EVT;
			gpio_mask  <= `CEGR_RST_MSK;
		end else begin
			if (evt_set) begin
				gpio_event <= 1'b1;
			end else if (evt_clr) begin
				gpio_event <= 1'b0;
			end
			if (msk_set) begin
				gpio_mask <= 1'b1;
			end else if (msk_clr) begin
				gpio_mask <= 1'b0;
			end
		end
	end

	assign irq = gpio_event & gpio_mask;

	always @* begin
		next_rdata = 32'h00000000;
		case (reg_addr)
			`CEGR_OFF_LINK_FEAT: begin
				next_rdata[`CEGR_LINK_ACCEL_BIT] = link_accel_support;
			end
			`CEGR_OFF_SUBSYS_ALIAS: begin
				next_rdata = subsystem_alias;
			end
			`CEGR_OFF_GPIO_CTRL: begin
				next_rdata[`CEGR_GPIO_IRQ_EN_BIT] = pin_three_irq_enable;
				next_rdata[`CEGR_GPIO_INV_BIT]    = pin_three_invert;
				next_rdata[`CEGR_GPIO_OE_BIT]     = pin_three_output_enable;
				next_rdata[`CEGR_GPIO_DATA_BIT]   = pin_logic_value;
			end
			`CEGR_OFF_INT_EVT_SET: begin
				next_rdata[`CEGR_EVT_GPIO_BIT] = gpio_event;
			end
			`CEGR_OFF_INT_EVT_CLR: begin
				next_rdata[`CEGR_EVT_GPIO_BIT] = gpio_event & gpio_mask;
			end
			`CEGR_OFF_INT_MSK_SET, `CEGR_OFF_INT_MSK_CLR: begin
				next_rdata[`CEGR_EVT_GPIO_BIT] = gpio_mask;
			end
			default: begin
				next_rdata = 32'h00000000;
			end
		endcase
	end

	// Read data stand only in the cycle after the strobe
	always @(posedge clk or negedge rst_sync) begin
		if (!rst_sync) begin
			reg_rdata <= 32'h00000000;
		end else if (reg_rd) begin
			reg_rdata <= next_rdata;
		end else begin
			reg_rdata <= 32'h00000000;
		end
	end

endmodule

// ==== bench/cegr_regs_asserts.sv ====
// Port assertions for the configuration extension registers
`timescale 1ns/10ps
module cegr_regs_chk (
	// Clock, reset and register port
	input wire        clk,
	input wire        resetn,
	input wire [7:0]  reg_addr,
	input wire [31:0] reg_wdata,
	input wire        reg_wr,
	input wire        reg_rd,
	input wire [31:0] reg_rdata,
	// Device side
	input wire        link_accel_support,
	input wire [31:0] subsystem_ident,
	input wire        general_pin_three_in,
	input wire        general_pin_three_out,
	input wire        general_pin_three_oe_n,
	input wire        irq
);
	default clocking @(posedge clk); endclocking
	default disable iff (!resetn);
	wire wfc = reg_wr && reg_addr == 8'hFC;
	alias_copy_a: assert property (reg_wr && reg_addr == 8'hF8 |=> subsystem_ident == $past(reg_wdata))
		else $error("alias copy");
	alias_read_a: assert property (reg_rd && reg_addr == 8'hF8 |=> reg_rdata == subsystem_ident)
		else $error("alias read");
	accel_bit_a: assert property (reg_wr && reg_addr == 8'hF4 |=> link_accel_support == $past(reg_wdata[1]))
		else $error("accel bit");
	link_rsvd_a: assert property (reg_rd && reg_addr == 8'hF4 |=> (reg_rdata & 32'h7D) == 32'h0)
		else $error("link reserved");
	gpio_rsvd_a: assert property (reg_rd && reg_addr == 8'hFC |=> (reg_rdata & 32'h4E00FFFF) == 32'h0)
		else $error("gpio reserved");
	// Control flop then drive flop: the pin outputs settle after the second edge past the write
	drive_enable_a: assert property (wfc |=> ##2 general_pin_three_oe_n == !$past(reg_wdata[28], 3))
		else $error("drive enable");
	drive_value_a: assert property (wfc |=> ##2
		general_pin_three_out == ($past(reg_wdata[24], 3) ^ $past(reg_wdata[29], 3))) else $error("drive value");
	mask_clear_a: assert property (reg_wr && reg_addr == 8'h8C && reg_wdata[0] |=> !irq)
		else $error("mask clear");
	cover property (irq);
	cover property ($fell(general_pin_three_oe_n));
	cover property (reg_rd && reg_addr == 8'h84 ##1 reg_rdata[0]);
endmodule
bind cegr_regs cegr_regs_chk u_cegr_regs_chk (.*);

// ==== bench/cegr_pin_model.sv ====
// Board logic on pin three
`timescale 1ns/10ps
module cegr_pin_model (
	// Block side and board level
	input wire  oe_n,
	input wire  out,
	input wire  lvl,
	output wire pin
);
	// Board drive backs off while the block drives, so the wire never fights
	assign pin = oe_n ? lvl : out;
endmodule

// ==== bench/testbench.sv ====
// Self-checking bench for the configuration extension registers
`timescale 1ns/10ps
module testbench;
	reg         clk = '0, resetn = '0, reg_wr = '0, reg_rd = '0, lvl = '0;
	reg  [7:0]  reg_addr = '0;
	reg  [31:0] reg_wdata = '0;
	wire [31:0] reg_rdata, ident;
	wire        accel, pin, pout, oe_n, irq;
	integer     fails = 0, samples_checked = 0;
	always #25 clk = ~clk;
	cegr_regs u_cegr_regs (.clk(clk), .resetn(resetn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .link_accel_support(accel),
		.subsystem_ident(ident), .general_pin_three_in(pin), .general_pin_three_out(pout),
		.general_pin_three_oe_n(oe_n), .irq(irq));
	cegr_pin_model u_cegr_pin_model (.oe_n(oe_n), .out(pout), .lvl(lvl), .pin(pin));
	task summarize;
		if (fails == 0 && samples_checked > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	task chk(input [31:0] g, input [31:0] e);
		samples_checked = samples_checked + 1;
		if (g !== e) begin
			fails = fails + 1;
			$display("Error %0t: got %h expected %h", $time, g, e);
		end
	endtask
	task wr(input [7:0] a, input [31:0] d);
		@(posedge clk) begin
			reg_wr <= 1'h1;
			reg_addr <= a;
			reg_wdata <= d;
		end
		@(posedge clk) reg_wr <= 1'h0;
	endtask
	task rd(input [7:0] a, input [31:0] m, input [31:0] e);
		@(posedge clk) begin
			reg_rd <= 1'h1;
			reg_addr <= a;
		end
		@(posedge clk) reg_rd <= 1'h0;
		#1 chk(reg_rdata & m, e);
	endtask
	// Output flop plus the two-flop pin synchroniser
	task settle;
		repeat (4) @(posedge clk);
		#1;
	endtask
	task t_regs;
		rd(8'hF8, 32'hFFFFFFFF, 32'h0);
		chk(oe_n, 32'h1);
		wr(8'hF8, 32'h1E07A5C3);
		wr(8'hF8, 32'hA5C31E07);
		rd(8'hF8, 32'hFFFF0000, 32'hA5C30000);
		rd(8'hF8, 32'h0000FFFF, 32'h00001E07);
		chk(ident, 32'hA5C31E07);
		wr(8'hF4, 32'hFFFFFFFF);
		rd(8'hF4, 32'h7F, 32'h2);
		chk(accel, 32'h1);
		wr(8'hF4, 32'h0);
		rd(8'hF4, 32'h7F, 32'h0);
	endtask
	task t_gpio;
		wr(8'hFC, 32'hFFFFFFFF);
		settle;
		chk({oe_n, pout}, 32'h0);
		rd(8'hFC, 32'hFF00FFFF, 32'hB1000000);
		wr(8'hFC, 32'h11000000);
		lvl <= 1'h1;
		settle;
		chk({oe_n, pout}, 32'h1);
		wr(8'hFC, 32'h20000000);
		settle;
		rd(8'hFC, 32'hFF00FFFF, 32'h20000000);
		wr(8'hFC, 32'h0);
		settle;
		rd(8'hFC, 32'hFF00FFFF, 32'h01000000);
	endtask
	task t_irq;
		wr(8'h88, 32'h1);
		wr(8'hFC, 32'h80000000);
		lvl <= 1'h0;
		settle;
		chk(irq, 32'h1);
		rd(8'h84, 32'h1, 32'h1);
		chk(irq, 32'h0);
		wr(8'hFC, 32'hA0000000);
		settle;
		chk(irq, 32'h0);
		wr(8'h8C, 32'h1);
		lvl <= 1'h1;
		settle;
		chk(irq, 32'h0);
		rd(8'h80, 32'h1, 32'h1);
		wr(8'h84, 32'h1);
		wr(8'hFC, 32'h0);
		lvl <= 1'h0;
		settle;
		rd(8'h80, 32'h1, 32'h0);
	endtask
	initial begin
		repeat (8) @(posedge clk);
		resetn <= 1'h1;
		repeat (3) @(posedge clk);
		t_regs;
		t_gpio;
		t_irq;
		summarize;
	end
	// The tests need some 95 cycles; 4000 means a hang
	initial begin
		#200000;
		fails = fails + 1;
		summarize;
	end
endmodule
